// [pkg/status_two_pkg.sv]
/*
 Shared constants and carriers for the second transceiver status register.
 Assumes a single system clock and a synchronous, active-high reset.
*/
package status_two_pkg;
    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam logic [5:0] STATUS_TWO_ADDR = 6'h08;
    localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
    localparam int RELEASE_BIT = 7;
    localparam int FAST_FORCE_BIT = 6;
    localparam int RESERVED_BIT = 5;
    localparam int SELECTED_BIT = 4;
    localparam int CIPHER_BIT = 3;
    localparam int PHASE_LSB = 0;
    localparam int PHASE_W = 3;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int GUARD_UNIT_NS = 5;
    localparam int GUARD_UNIT_CYC = (GUARD_UNIT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    // Phase codes as reported in bits 2..0
    localparam logic [2:0] PH_IDLE = 3'h0;
    localparam logic [2:0] PH_LAUNCH = 3'h1;
    localparam logic [2:0] PH_TX_GUARD = 3'h2;
    localparam logic [2:0] PH_SEND = 3'h3;
    localparam logic [2:0] PH_RX_GUARD = 3'h4;
    localparam logic [2:0] PH_WAIT_DATA = 3'h5;
    localparam logic [2:0] PH_RECEIVE = 3'h6;

    // Host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Events from the command and transceiver logic
    typedef struct packed {
        logic auto_anticollision_command;
        logic passive_mode;
        logic select_or_poll_answered;
        logic card_authenticate_ok;
        logic field_present;
        logic temp_below_limit;
        logic overheat_event;
        logic command_start;
        logic reader_card_mode;
    } core_evt_t;

    // Transceiver sequencing inputs
    typedef struct packed {
        logic tx_request;
        logic transmit_launch;
        logic tx_field_wait_enable;
        logic rx_field_wait_enable;
        logic tx_done;
        logic rx_start;
        logic rx_done;
        logic [7:0] tx_guard_time_register;
        logic [7:0] rx_guard_time_register;
    } trx_ctl_t;
endpackage

// [rtl/field_sync.sv]
/*
 Two-stage synchroniser for asynchronous pin levels.
 Assumes the inputs are plain levels with no timing relation to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module field_sync #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // --------------------------------------------------------------
    // Two flops; only the second stage is visible
    // --------------------------------------------------------------
    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// [rtl/guard_timer.sv]
/*
 Minimum-duration guard counter for the transceiver phases.
 Assumes load comes from logic on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module guard_timer #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] min_time,
    output logic expired
);
    import status_two_pkg::*;

    typedef struct packed {
        logic [WIDTH+3:0] cnt;
    } gt_state_t;

    gt_state_t st_r;
    gt_state_t st_nxt;

    // --------------------------------------------------------------
    // Countdown
    // --------------------------------------------------------------
    // Load converts guard units into cycles, then counts to zero
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = (WIDTH+4)'(min_time) * (WIDTH+4)'(GUARD_UNIT_CYC);
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - (WIDTH+4)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Expiry looks at the count only: the sequencer derives load from
    // its own next phase, so a load term here would close a loop
    assign expired = (st_r.cnt == '0);
endmodule
`default_nettype wire

// [rtl/transceiver_status_two.sv]
/*
 Second transceiver status register with overheat latch and the
 transmit/receive phase sequencer whose state it reports.
 Assumes the host port and command logic run on sys_clk; the field
 detector and two-wire speed indication are pins and are synchronised.
 Guard phases count whole clock cycles per guard unit; a guard time of
 zero still costs one cycle in that phase. Setting events win over a
 same-cycle clear for every flag. Reads of other addresses return zero,
 and the release bit reads as one only in the cycle after its write.
*/
// Operation
// - Register at address 08h, all zeros after reset.
// - Release bit clears overheat error only while below 125 degrees.
// - Fast-force bit set puts two-wire filter in high-speed mode.
// - Fast-force bit clear makes filter follow actual protocol speed.
// - Listener flag sets when select or polling command answered.
// - Listener flag sets only during auto anticollision in passive mode.
// - Listener flag clears when external RF field goes away.
// - Cipher flag set means card data is encrypted.
// - Cipher flag sets only on successful card authentication.
// - Cipher flag counts only in reader mode with the card family.
// - Phase field reports idle, launch, guards, send, wait, receive.
// - Phase 001 holds off until transmit launch is written.
// - Phase 010 waits for RF field when tx field wait enabled.
// - Phase 010 lasts at least the tx guard time.
// - Phase 100 waits for RF field when rx field wait enabled.
// - Phase 100 lasts at least the rx guard time.
// - Command start clears errors except overheat; release clears it.
`timescale 1ns/100ps
`default_nettype none
module transceiver_status_two #(
    parameter int GUARD_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire status_two_pkg::reg_req_t host_req,
    output logic [7:0] host_rdata,
    input wire status_two_pkg::core_evt_t core_evt,
    input wire status_two_pkg::trx_ctl_t trx_ctl,
    input wire logic rf_field_pin,
    input wire logic two_wire_fast_pin,
    output logic overheat_error,
    output logic two_wire_filter_fast,
    output logic card_cipher_active,
    output logic cipher_enable,
    output logic listener_selected_flag,
    output logic tx_active,
    output logic rx_active,
    output logic [2:0] transceiver_phase
);
    import status_two_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Sequencer states in reporting order
    typedef enum {
        S_IDLE,
        S_LAUNCH,
        S_TX_GUARD,
        S_SEND,
        S_RX_GUARD,
        S_WAIT_DATA,
        S_RECEIVE
    } phase_t;

    // All state in one word; read data is captured into flops
    typedef struct packed {
        logic release_bit;
        logic fast_force;
        logic selected;
        logic cipher;
        logic overheat;
        logic [7:0] rdata;
        phase_t phase;
    } st_t;

    st_t st_r;
    st_t st_nxt;
    // Synchronised pins, host decode and guard timer handshakes
    logic [1:0] pins_sync;
    logic field_on;
    logic fast_proto;
    logic wr_hit;
    logic rd_hit;
    logic tx_guard_load;
    logic rx_guard_load;
    logic tx_guard_done;
    logic rx_guard_done;

    // Phase code for an enumerated state
    function automatic logic [2:0] phase_code(input phase_t p);
        case (p)
            S_IDLE: phase_code = PH_IDLE;
            S_LAUNCH: phase_code = PH_LAUNCH;
            S_TX_GUARD: phase_code = PH_TX_GUARD;
            S_SEND: phase_code = PH_SEND;
            S_RX_GUARD: phase_code = PH_RX_GUARD;
            S_WAIT_DATA: phase_code = PH_WAIT_DATA;
            S_RECEIVE: phase_code = PH_RECEIVE;
            default: phase_code = PH_IDLE;
        endcase
    endfunction

    // Address decode shared by the read and the write path
    function automatic logic addr_hit(input logic [5:0] a);
        addr_hit = (a == STATUS_TWO_ADDR);
    endfunction

    // A guard phase ends once its minimum time is over and, when the
    // matching wait enable asks for it, the RF field is present
    function automatic logic guard_clear(input logic done,
        input logic field, input logic wait_en);
        guard_clear = done && (field || !wait_en);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Field detector and speed indication have no relation to sys_clk
    field_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({rf_field_pin, two_wire_fast_pin}),
        .sync_out(pins_sync)
    );

    // Bit order follows the concatenation at the synchroniser input
    assign field_on = pins_sync[1];
    assign fast_proto = pins_sync[0];

    // ----------------------------------------------------------------
    // Guard timers
    // ----------------------------------------------------------------
    // One timer per guard phase so each keeps its own programmed time
    guard_timer #(
        .WIDTH(GUARD_W)
    ) u_tx_guard (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(tx_guard_load),
        .min_time(trx_ctl.tx_guard_time_register[GUARD_W-1:0]),
        .expired(tx_guard_done)
    );

    guard_timer #(
        .WIDTH(GUARD_W)
    ) u_rx_guard (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(rx_guard_load),
        .min_time(trx_ctl.rx_guard_time_register[GUARD_W-1:0]),
        .expired(rx_guard_done)
    );

    // ----------------------------------------------------------------
    // Host decode
    // ----------------------------------------------------------------
    // Strobes only count when they address this register
    assign wr_hit = host_req.wr && addr_hit(host_req.addr);
    assign rd_hit = host_req.rd && addr_hit(host_req.addr);

    // Timers load on entry to their guard phase
    assign tx_guard_load = (st_r.phase != S_TX_GUARD)
        && (st_nxt.phase == S_TX_GUARD);
    assign rx_guard_load = (st_r.phase != S_RX_GUARD)
        && (st_nxt.phase == S_RX_GUARD);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Release bit is a strobe; it reads as one for a single cycle
        st_nxt.release_bit = 1'b0;
        // Host writes to the read/write bits
        if (wr_hit) begin
            st_nxt.release_bit = host_req.wdata[RELEASE_BIT];
            st_nxt.fast_force = host_req.wdata[FAST_FORCE_BIT];
            if (!host_req.wdata[CIPHER_BIT]) begin
                st_nxt.cipher = 1'b0;
            end
        end
        // Authentication wins over a same-cycle host clear
        if (core_evt.card_authenticate_ok) begin
            st_nxt.cipher = 1'b1;
        end
        // Overheat: release only below limit; set wins
        if (wr_hit && host_req.wdata[RELEASE_BIT]
            && core_evt.temp_below_limit) begin
            st_nxt.overheat = 1'b0;
        end
        // Command start leaves overheat untouched
        if (core_evt.overheat_event) begin
            st_nxt.overheat = 1'b1;
        end
        // Listener flag: cleared when field drops, set wins
        if (!field_on) begin
            st_nxt.selected = 1'b0;
        end
        if (core_evt.select_or_poll_answered
            && core_evt.auto_anticollision_command
            && core_evt.passive_mode) begin
            st_nxt.selected = 1'b1;
        end
        // Phase sequencer; each event is taken only in its own phase,
        // so a stray pulse elsewhere leaves the phase alone
        case (st_r.phase)
            S_IDLE: begin
                if (trx_ctl.tx_request) begin
                    st_nxt.phase = S_LAUNCH;
                end
            end
            S_LAUNCH: begin
                if (trx_ctl.transmit_launch) begin
                    st_nxt.phase = S_TX_GUARD;
                end
            end
            S_TX_GUARD: begin
                if (guard_clear(tx_guard_done, field_on,
                    trx_ctl.tx_field_wait_enable)) begin
                    st_nxt.phase = S_SEND;
                end
            end
            S_SEND: begin
                if (trx_ctl.tx_done) begin
                    st_nxt.phase = S_RX_GUARD;
                end
            end
            S_RX_GUARD: begin
                if (guard_clear(rx_guard_done, field_on,
                    trx_ctl.rx_field_wait_enable)) begin
                    st_nxt.phase = S_WAIT_DATA;
                end
            end
            S_WAIT_DATA: begin
                if (trx_ctl.rx_start) begin
                    st_nxt.phase = S_RECEIVE;
                end
            end
            S_RECEIVE: begin
                if (trx_ctl.rx_done) begin
                    st_nxt.phase = S_IDLE;
                end
            end
            default: begin
                st_nxt.phase = S_IDLE;
            end
        endcase
        // Read data captured from the current state
        st_nxt.rdata = 8'h00;
        if (rd_hit) begin
            st_nxt.rdata[RELEASE_BIT] = st_r.release_bit;
            st_nxt.rdata[FAST_FORCE_BIT] = st_r.fast_force;
            st_nxt.rdata[RESERVED_BIT] = 1'b0;
            st_nxt.rdata[SELECTED_BIT] = st_r.selected;
            st_nxt.rdata[CIPHER_BIT] = st_r.cipher;
            st_nxt.rdata[PHASE_LSB +: PHASE_W] = phase_code(st_r.phase);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Reset loads the all-zero status byte and an idle sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.release_bit <= STATUS_TWO_RESET[RELEASE_BIT];
            st_r.fast_force <= STATUS_TWO_RESET[FAST_FORCE_BIT];
            st_r.selected <= STATUS_TWO_RESET[SELECTED_BIT];
            st_r.cipher <= STATUS_TWO_RESET[CIPHER_BIT];
            st_r.overheat <= 1'b0;
            st_r.rdata <= STATUS_TWO_RESET;
            st_r.phase <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Read data and flags straight from the state register
    assign host_rdata = st_r.rdata;
    assign overheat_error = st_r.overheat;
    // Forced fast, else follow the protocol in use
    assign two_wire_filter_fast = st_r.fast_force
        || fast_proto;
    assign card_cipher_active = st_r.cipher;
    // Encryption only applies in reader mode with the card family
    assign cipher_enable = st_r.cipher
        && core_evt.reader_card_mode;
    assign listener_selected_flag = st_r.selected;
    // Datapath enables decoded from the registered phase
    assign tx_active = (st_r.phase == S_SEND);
    assign rx_active = (st_r.phase == S_RECEIVE);
    assign transceiver_phase = phase_code(st_r.phase);
endmodule
`default_nettype wire

// [tb/status_two_host.sv]
/*
 Host controller model driving the register port.
 Assumes the bench calls its tasks from one process, just after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
module status_two_host (
    input wire logic sys_clk,
    output var status_two_pkg::reg_req_t host_req
);
    import status_two_pkg::*;

    // Idle port at time zero
    initial host_req = '0;

    // One-cycle strobes; stale address and data are inverted on release
    task automatic access(input logic w, input logic [5:0] a,
        input logic [7:0] d);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge sys_clk);
    endtask

    // Host ends encrypted traffic by writing zero
    task automatic end_cipher();
        access(1'b1, STATUS_TWO_ADDR, 8'h00);
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
 Self-checking bench for the second status register block.
 Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import status_two_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    core_evt_t core_evt = '0;
    trx_ctl_t trx_ctl = '0;
    logic rf_field_pin = 1'b1;
    logic two_wire_fast_pin = 1'b0;
    reg_req_t host_req;
    logic [7:0] host_rdata;
    logic overheat_error, two_wire_filter_fast, card_cipher_active;
    logic cipher_enable, listener_selected_flag, tx_active, rx_active;
    logic [2:0] transceiver_phase;
    logic [7:0] ph_obs;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    int seed = 84;
    int n;

    always #2.5 sys_clk = ~sys_clk;

    // Phase with both datapath enables above it
    assign ph_obs = {3'h0, tx_active, rx_active, transceiver_phase};

    transceiver_status_two #(.GUARD_W(8)) DUT (.sys_clk(sys_clk),
        .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
        .core_evt(core_evt), .trx_ctl(trx_ctl),
        .rf_field_pin(rf_field_pin), .two_wire_fast_pin(two_wire_fast_pin),
        .overheat_error(overheat_error), .cipher_enable(cipher_enable),
        .two_wire_filter_fast(two_wire_filter_fast),
        .card_cipher_active(card_cipher_active),
        .listener_selected_flag(listener_selected_flag),
        .tx_active(tx_active), .rx_active(rx_active),
        .transceiver_phase(transceiver_phase));
    status_two_host host (.sys_clk(sys_clk), .host_req(host_req));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask

    // Stays in a guard phase while counting; optionally withholds field
    task automatic guard(input logic [2:0] code, input int g,
        input bit hold);
        int c;
        c = 0;
        while (transceiver_phase === code && c < 300) begin
            if (hold && c == g + 6)
                rf_field_pin <= 1'b1;
            c++;
            wt(1);
        end
        chk(8'(c > g), 8'h01);
        chk(8'(!hold || c > g + 6), 8'h01);
    endtask

    task automatic conclude();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Read data lands one cycle after the strobe, zero otherwise
    always @(posedge sys_clk) begin
        if (rd_d)
            chk(host_rdata, exp_q.pop_front());
        else if (!rst)
            chk(host_rdata, 8'h00);
        rd_d <= host_req.rd;
    end

    // Whole run is under two hundred cycles; this limit is far beyond it
    initial begin
        #100000;
        miscompares++;
        conclude();
    end

    initial begin
        wt(8);
        rst <= 1'b0;
        wt(1);
        n = $random(seed);
        host.access(1'b1, 6'(9 + (n & 31)), 8'h40);
        rd_chk(STATUS_TWO_ADDR, STATUS_TWO_RESET);
        // Only bit 6 of this byte may stick
        host.access(1'b1, STATUS_TWO_ADDR, 8'h7F);
        chk({7'h0, two_wire_filter_fast}, 8'h01);
        rd_chk(STATUS_TWO_ADDR, 8'h40);
        host.access(1'b1, STATUS_TWO_ADDR, 8'h00);
        for (int p = 1; p >= 0; p--) begin
            two_wire_fast_pin <= p[0];
            wt(4);
            chk({7'h0, two_wire_filter_fast}, 8'(p));
        end
        // Cipher flag from authentication, gated by reader mode
        core_evt.card_authenticate_ok <= 1'b1;
        wt(1);
        core_evt.card_authenticate_ok <= 1'b0;
        wt(1);
        chk({6'h0, card_cipher_active, cipher_enable}, 8'h02);
        core_evt.reader_card_mode <= 1'b1;
        wt(1);
        chk({6'h0, card_cipher_active, cipher_enable}, 8'h03);
        rd_chk(STATUS_TWO_ADDR, 8'h08);
        host.end_cipher();
        chk({7'h0, card_cipher_active}, 8'h00);
        // Answers select only in passive anticollision
        for (int m = 0; m < 4; m++) begin
            core_evt.auto_anticollision_command <= m[0];
            core_evt.passive_mode <= m[1];
            core_evt.select_or_poll_answered <= 1'b1;
            wt(1);
            core_evt.select_or_poll_answered <= 1'b0;
            wt(1);
            chk({7'h0, listener_selected_flag}, 8'(m == 3));
        end
        rd_chk(STATUS_TWO_ADDR, 8'h10);
        rf_field_pin <= 1'b0;
        wt(5);
        chk({7'h0, listener_selected_flag}, 8'h00);
        // Overheat survives command start and a hot release
        core_evt.overheat_event <= 1'b1;
        core_evt.command_start <= 1'b1;
        wt(1);
        core_evt <= '{reader_card_mode: 1'b1, default: 1'b0};
        host.access(1'b1, STATUS_TWO_ADDR, 8'h80);
        chk({7'h0, overheat_error}, 8'h01);
        core_evt.temp_below_limit <= 1'b1;
        host.access(1'b1, STATUS_TWO_ADDR, 8'h80);
        chk({7'h0, overheat_error}, 8'h00);
        // Full transfer, second pass withholds the field in both guards
        for (int k = 0; k < 2; k++) begin
            n = 3 + ($random(seed) & 7);
            trx_ctl.tx_guard_time_register <= 8'(n);
            trx_ctl.rx_guard_time_register <= 8'(n + 1);
            trx_ctl.tx_field_wait_enable <= k[0];
            trx_ctl.rx_field_wait_enable <= k[0];
            rf_field_pin <= !k[0];
            trx_ctl.tx_request <= 1'b1;
            wt(1);
            trx_ctl.tx_request <= 1'b0;
            wt(6);
            rd_chk(STATUS_TWO_ADDR, {5'h0, PH_LAUNCH});
            trx_ctl.transmit_launch <= 1'b1;
            wt(1);
            trx_ctl.transmit_launch <= 1'b0;
            wt(1);
            guard(PH_TX_GUARD, n, k[0]);
            chk(ph_obs, {5'h02, PH_SEND});
            rf_field_pin <= !k[0];
            trx_ctl.tx_done <= 1'b1;
            wt(1);
            trx_ctl.tx_done <= 1'b0;
            wt(1);
            guard(PH_RX_GUARD, n + 1, k[0]);
            rd_chk(STATUS_TWO_ADDR, {5'h0, PH_WAIT_DATA});
            trx_ctl.rx_start <= 1'b1;
            wt(1);
            trx_ctl.rx_start <= 1'b0;
            rd_chk(STATUS_TWO_ADDR, {5'h0, PH_RECEIVE});
            chk(ph_obs, {5'h01, PH_RECEIVE});
            trx_ctl.rx_done <= 1'b1;
            wt(1);
            trx_ctl.rx_done <= 1'b0;
            wt(1);
            chk(ph_obs, {5'h00, PH_IDLE});
        end
        conclude();
    end
endmodule
`default_nettype wire

// [tb/transceiver_status_two_chk.sv]
/*
 Assertion checker for the second status register block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module transceiver_status_two_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire status_two_pkg::reg_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire status_two_pkg::core_evt_t core_evt,
    input wire status_two_pkg::trx_ctl_t trx_ctl,
    input wire logic rf_field_pin,
    input wire logic overheat_error,
    input wire logic two_wire_filter_fast,
    input wire logic card_cipher_active,
    input wire logic cipher_enable,
    input wire logic listener_selected_flag,
    input wire logic [2:0] transceiver_phase
);
    import status_two_pkg::*;
    logic wr_here;
    logic release_ok;

    // Decoded host write and a legal overheat release
    assign wr_here = host_req.wr && host_req.addr == STATUS_TWO_ADDR;
    assign release_ok = wr_here && host_req.wdata[RELEASE_BIT] &&
        core_evt.temp_below_limit;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // -------------------------------------------------------------
    // Register bits, flags and phase sequencing
    // -------------------------------------------------------------
    a_reserved_zero: assert property (!host_rdata[RESERVED_BIT])
        else $error("reserved bit read back as one");
    a_phase_legal: assert property (transceiver_phase != 3'h7)
        else $error("undefined phase code reported");
    a_force_fast: assert property (
        wr_here && host_req.wdata[FAST_FORCE_BIT] |=> two_wire_filter_fast)
        else $error("filter not forced fast after write");
    a_cipher_gate: assert property (
        cipher_enable == (card_cipher_active && core_evt.reader_card_mode))
        else $error("cipher enable not gated by reader mode");
    a_cipher_cause: assert property ($rose(card_cipher_active) |->
        $past(core_evt.card_authenticate_ok))
        else $error("cipher flag set without authentication");
    a_listener_cause: assert property (
        $rose(listener_selected_flag) |-> $past(core_evt.passive_mode &&
        core_evt.select_or_poll_answered &&
        core_evt.auto_anticollision_command))
        else $error("listener flag set outside anticollision");
    a_listener_drop: assert property ((!rf_field_pin) [*4] ##0
        !core_evt.select_or_poll_answered |=> !listener_selected_flag)
        else $error("listener flag kept with field off");
    a_launch_hold: assert property (
        transceiver_phase == PH_LAUNCH && !trx_ctl.transmit_launch |=>
        transceiver_phase == PH_LAUNCH)
        else $error("left launch wait without launch");
    a_tx_field_wait: assert property (
        transceiver_phase == PH_TX_GUARD && trx_ctl.tx_field_wait_enable &&
        !$past(rf_field_pin) && !$past(rf_field_pin, 2) &&
        !$past(rf_field_pin, 3) |=> transceiver_phase == PH_TX_GUARD)
        else $error("tx guard left with no field");
    a_tx_guard_min: assert property (
        transceiver_phase == PH_TX_GUARD &&
        $past(transceiver_phase) == PH_LAUNCH &&
        trx_ctl.tx_guard_time_register >= 8'h03 |=>
        (transceiver_phase == PH_TX_GUARD) [*2])
        else $error("tx guard shorter than programmed");
    a_overheat_hold: assert property (
        overheat_error && !release_ok |=> overheat_error)
        else $error("overheat error lost without release");

    // Main scenarios reached
    c_cipher_on: cover property ($rose(card_cipher_active));
    c_listener_on: cover property ($rose(listener_selected_flag));
    c_receiving: cover property (transceiver_phase == PH_RECEIVE);
endmodule

bind transceiver_status_two transceiver_status_two_chk chk (
    .sys_clk(sys_clk), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .core_evt(core_evt), .trx_ctl(trx_ctl),
    .rf_field_pin(rf_field_pin), .overheat_error(overheat_error),
    .two_wire_filter_fast(two_wire_filter_fast),
    .card_cipher_active(card_cipher_active),
    .cipher_enable(cipher_enable),
    .listener_selected_flag(listener_selected_flag),
    .transceiver_phase(transceiver_phase));
`default_nettype wire
